// file: design/apth_pkg.sv
// package of constants and types for the absolute position transfer host
package apth_pkg;
    // apb register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CMD_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] POS_OFS = 8'h0C;
    localparam logic [7:0] HOME_OFS = 8'h10;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
    // control register fields
    localparam int CTRL_SERVO_BIT = 0;
    localparam int CTRL_HOMEMODE_BIT = 1;
    localparam int CTRL_TLIM_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // command register fields, write-only pulses
    localparam int CMD_START_BIT = 0;
    localparam int CMD_ALMRST_BIT = 1;
    localparam int CMD_HOME_BIT = 2;
    // status and interrupt fields
    localparam int STAT_W = 8;
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_COMM_BIT = 1;
    localparam int IRQ_CSUM_BIT = 2;
    localparam int IRQ_HOME_BIT = 3;
    localparam logic [31:0] HOME_RST = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
    // frame layout: sixteen data units then three checksum units
    localparam int UNIT_BITS = 2;
    localparam int DATA_UNITS = 16;
    localparam int CSUM_UNITS = 3;
    localparam int CSUM_W = 6;
    localparam int MAX_RETRY = 3;
    // timing, times in ms, counts derived from the clock rate
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int MODE_TIMEOUT_MS = 5000;
    localparam int HS_TIMEOUT_MS = 1000;
    localparam int SAMPLE_DELAY_MS = 10;
    localparam int RETRY_WAIT_MS = 100;
    localparam int CLEAR_PULSE_MS = 100;
    localparam int MODE_TIMEOUT_CYC = MODE_TIMEOUT_MS * CYC_PER_MS;
    localparam int HS_TIMEOUT_CYC = HS_TIMEOUT_MS * CYC_PER_MS;
    localparam int SAMPLE_DELAY_CYC = SAMPLE_DELAY_MS * CYC_PER_MS;
    localparam int RETRY_WAIT_CYC = RETRY_WAIT_MS * CYC_PER_MS;
    localparam int CLEAR_PULSE_CYC = CLEAR_PULSE_MS * CYC_PER_MS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REQ_HI,
        ST_REQ_LO,
        ST_SETTLE,
        ST_CHECK,
        ST_RETRY_WAIT
    } apth_state_t;
endpackage

// file: design/apth_reg_if.sv
// carrier between the transfer core and its apb register block
`timescale 1ns/1ps
interface apth_reg_if;
    logic servoOn;
    logic homingMode;
    logic torqueLimitEn;
    logic startPulse;
    logic almRstPulse;
    logic homePulse;
    logic [31:0] homeAddr;
    logic [31:0] absPos;
    logic [apth_pkg::STAT_W-1:0] status;
    logic [apth_pkg::IRQ_W-1:0] events;

    modport regs (
        output servoOn, homingMode, torqueLimitEn,
        output startPulse, almRstPulse, homePulse, homeAddr,
        input absPos, status, events
    );
    modport core (
        input servoOn, homingMode, torqueLimitEn,
        input startPulse, almRstPulse, homePulse, homeAddr,
        output absPos, status, events
    );
endinterface

// file: design/apth_timer.sv
// elapsed-time counter with restart and a limit input
`timescale 1ns/1ps
module apth_timer #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic run,
    input wire logic clr,
    input wire logic [W-1:0] limit,
    // result
    output logic done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    assign done = run && !clr && (cnt_q >= limit - W'(1));
    // saturate so a long stall cannot wrap into a false short wait
    assign cnt_d = (!run || clr) ? '0 : (done ? cnt_q : cnt_q + W'(1));

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end
endmodule

// file: design/apth_apb_regs.sv
// apb slave holding control, command, status and interrupt registers
`timescale 1ns/1ps
module apth_apb_regs (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core side
    apth_reg_if.regs rif,
    // interrupt
    output logic irq
);
    logic [2:0] ctrl_q;
    logic [31:0] home_q;
    logic [apth_pkg::IRQ_W-1:0] irqStat_q;
    logic [apth_pkg::IRQ_W-1:0] irqMask_q;
    logic [apth_pkg::IRQ_W-1:0] irqStat_d;
    logic access;
    logic wr;
    logic mapped;
    logic [31:0] rdMux;

    assign access = psel && penable;
    assign wr = access && pwrite;
    assign mapped = (paddr == apth_pkg::CTRL_OFS)
        || (paddr == apth_pkg::CMD_OFS) || (paddr == apth_pkg::STAT_OFS)
        || (paddr == apth_pkg::POS_OFS) || (paddr == apth_pkg::HOME_OFS)
        || (paddr == apth_pkg::IRQ_STAT_OFS)
        || (paddr == apth_pkg::IRQ_MASK_OFS);
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    assign rdMux =
        (paddr == apth_pkg::CTRL_OFS) ? {29'h0, ctrl_q} :
        (paddr == apth_pkg::STAT_OFS) ? {24'h0, rif.status} :
        (paddr == apth_pkg::POS_OFS) ? rif.absPos :
        (paddr == apth_pkg::HOME_OFS) ? home_q :
        (paddr == apth_pkg::IRQ_STAT_OFS) ? {28'h0, irqStat_q} :
        (paddr == apth_pkg::IRQ_MASK_OFS) ? {28'h0, irqMask_q} : 32'h0;
    assign prdata = (access && !pwrite) ? rdMux : 32'h0;

    // new events win over a write-one clear in the same cycle
    assign irqStat_d = (irqStat_q & ~((wr && paddr == apth_pkg::IRQ_STAT_OFS)
        ? pwdata[apth_pkg::IRQ_W-1:0] : '0)) | rif.events;
    assign irq = |(irqStat_q & irqMask_q);

    assign rif.servoOn = ctrl_q[apth_pkg::CTRL_SERVO_BIT];
    assign rif.homingMode = ctrl_q[apth_pkg::CTRL_HOMEMODE_BIT];
    assign rif.torqueLimitEn = ctrl_q[apth_pkg::CTRL_TLIM_BIT];
    assign rif.homeAddr = home_q;
    assign rif.startPulse = wr && paddr == apth_pkg::CMD_OFS
        && pwdata[apth_pkg::CMD_START_BIT];
    assign rif.almRstPulse = wr && paddr == apth_pkg::CMD_OFS
        && pwdata[apth_pkg::CMD_ALMRST_BIT];
    assign rif.homePulse = wr && paddr == apth_pkg::CMD_OFS
        && pwdata[apth_pkg::CMD_HOME_BIT];

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= apth_pkg::CTRL_RST;
            home_q <= apth_pkg::HOME_RST;
            irqMask_q <= apth_pkg::IRQ_MASK_RST;
            irqStat_q <= '0;
        end
        else
        begin
            irqStat_q <= irqStat_d;
            if (wr && paddr == apth_pkg::CTRL_OFS)
                ctrl_q <= pwdata[2:0];
            if (wr && paddr == apth_pkg::HOME_OFS)
                home_q <= pwdata;
            if (wr && paddr == apth_pkg::IRQ_MASK_OFS)
                irqMask_q <= pwdata[apth_pkg::IRQ_W-1:0];
        end
    end
endmodule

// file: design/apth_host.sv
// controller that drives the absolute position transfer and homing pins
`timescale 1ns/1ps
module apth_host #(
    parameter int MODE_TIMEOUT = apth_pkg::MODE_TIMEOUT_CYC,
    parameter int HS_TIMEOUT = apth_pkg::HS_TIMEOUT_CYC,
    parameter int SAMPLE_DELAY = apth_pkg::SAMPLE_DELAY_CYC,
    parameter int RETRY_WAIT = apth_pkg::RETRY_WAIT_CYC,
    parameter int CLEAR_PULSE = apth_pkg::CLEAR_PULSE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // amplifier inputs
    input wire logic sharedIn0,
    input wire logic sharedIn1,
    input wire logic sharedIn2,
    input wire logic brakeReleaseSignal,
    // amplifier outputs
    output logic servoEnableCmd,
    output logic xferMode,
    output logic absRequest,
    output logic alarmResetOut,
    output logic deviationClear,
    output logic brakeOut,
    output logic torqueLimitCmd,
    // controller inputs
    input wire logic controllerRun,
    input wire logic estopActive,
    input wire logic homingStartButton,
    // positioning module
    output logic motionInhibit,
    output logic [31:0] modHomeAddr,
    output logic [31:0] modPresentPos,
    output logic modLoad
);
    localparam int UW = 5;
    localparam logic [UW-1:0] LAST_UNIT =
        UW'(apth_pkg::DATA_UNITS + apth_pkg::CSUM_UNITS - 1);
    localparam logic [UW-1:0] FIRST_CSUM = UW'(apth_pkg::DATA_UNITS);

    apth_reg_if rif();

    apth_pkg::apth_state_t st_q, st_d, stPrev_q;
    logic [31:0] abs_q, abs_d;
    logic [apth_pkg::CSUM_W-1:0] sum_q, sum_d, csum_q, csum_d;
    logic [UW-1:0] unit_q, unit_d;
    logic [1:0] retry_q, retry_d;
    logic commErr_q, commErr_d, csumErr_q, csumErr_d;
    logic valid_q, valid_d;
    logic mode_q, mode_d, req_q, req_d;
    logic [31:0] presPos_q, presPos_d;
    logic load_q, load_d;
    logic clrOn_q;
    logic servoPrev_q, runPrev_q, estopPrev_q, btnPrev_q;
    logic almRst_q;
    logic evDone, evComm, evCsum, evHome;
    logic trigger, homeStart, inXfer, entered;
    logic modeDone, hsDone, dlyDone, clrDone;
    logic [1:0] rxBits;

    apth_apb_regs u_regs (
        .clk(clk),
        .nrst(nrst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rif(rif.regs),
        .irq(irq)
    );

    // sharedIn0 and sharedIn1 mean data only while the mode is asserted; sharedIn2 is then the ready line
    assign rxBits = {sharedIn1, sharedIn0};
    assign inXfer = st_q != apth_pkg::ST_IDLE
        && st_q != apth_pkg::ST_RETRY_WAIT;
    assign entered = st_q != stPrev_q;

    // servo-on rising stands in for amplifier power-up
    assign trigger = rif.servoOn && (rif.startPulse
        || (rif.servoOn && !servoPrev_q)
        || (controllerRun && !runPrev_q)
        || almRst_q
        || (!estopActive && estopPrev_q));

    apth_timer u_modeTmr (
        .clk(clk),
        .nrst(nrst),
        .run(mode_q),
        .clr(1'b0),
        .limit(32'(MODE_TIMEOUT)),
        .done(modeDone)
    );
    // one timer serves both handshake waits; restarted on each entry
    apth_timer u_hsTmr (
        .clk(clk),
        .nrst(nrst),
        .run(st_q == apth_pkg::ST_REQ_HI || st_q == apth_pkg::ST_REQ_LO),
        .clr(entered),
        .limit(32'(HS_TIMEOUT)),
        .done(hsDone)
    );
    apth_timer u_dlyTmr (
        .clk(clk),
        .nrst(nrst),
        .run(st_q == apth_pkg::ST_SETTLE || st_q == apth_pkg::ST_RETRY_WAIT),
        .clr(entered),
        .limit(st_q == apth_pkg::ST_SETTLE ? 32'(SAMPLE_DELAY)
            : 32'(RETRY_WAIT)),
        .done(dlyDone)
    );
    apth_timer u_clrTmr (
        .clk(clk),
        .nrst(nrst),
        .run(clrOn_q),
        .clr(1'b0),
        .limit(32'(CLEAR_PULSE)),
        .done(clrDone)
    );

    // homing only in homing mode, at rest, with no transfer running
    assign homeStart = rif.homingMode && st_q == apth_pkg::ST_IDLE
        && !trigger && !clrOn_q && sharedIn0 && (rif.homePulse
        || (homingStartButton && !btnPrev_q));

    always_comb
    begin
        st_d = st_q;
        abs_d = abs_q;
        sum_d = sum_q;
        csum_d = csum_q;
        unit_d = unit_q;
        retry_d = retry_q;
        commErr_d = commErr_q;
        csumErr_d = csumErr_q;
        valid_d = valid_q;
        mode_d = mode_q;
        req_d = req_q;
        presPos_d = presPos_q;
        load_d = 1'b0;
        evDone = 1'b0;
        evComm = 1'b0;
        evCsum = 1'b0;
        unique case (st_q)
            apth_pkg::ST_IDLE:
            begin
                if (trigger)
                begin
                    retry_d = '0;
                    commErr_d = 1'b0;
                    csumErr_d = 1'b0;
                    valid_d = 1'b0;
                    unit_d = '0;
                    sum_d = '0;
                    mode_d = 1'b1;
                    st_d = apth_pkg::ST_REQ_HI;
                end
            end
            apth_pkg::ST_REQ_HI:
            begin
                req_d = 1'b1;
                if (!sharedIn2)
                    st_d = apth_pkg::ST_REQ_LO;
            end
            apth_pkg::ST_REQ_LO:
            begin
                req_d = 1'b0;
                if (sharedIn2)
                    st_d = apth_pkg::ST_SETTLE;
            end
            apth_pkg::ST_SETTLE:
            begin
                if (dlyDone)
                begin
                    if (unit_q < FIRST_CSUM)
                    begin
                        abs_d[{unit_q[3:0], 1'b0} +: 2] = rxBits;
                        sum_d = sum_q + {4'h0, rxBits};
                    end
                    else
                        csum_d[{unit_q[1:0], 1'b0} +: 2] = rxBits;
                    unit_d = unit_q + UW'(1);
                    st_d = (unit_q == LAST_UNIT) ? apth_pkg::ST_CHECK
                        : apth_pkg::ST_REQ_HI;
                end
            end
            apth_pkg::ST_CHECK:
            begin
                mode_d = 1'b0;
                if (sum_q == csum_q)
                begin
                    valid_d = 1'b1;
                    presPos_d = abs_q;
                    load_d = 1'b1;
                    evDone = 1'b1;
                    st_d = apth_pkg::ST_IDLE;
                end
                else if (retry_q == 2'(apth_pkg::MAX_RETRY))
                begin
                    csumErr_d = 1'b1;
                    evCsum = 1'b1;
                    st_d = apth_pkg::ST_IDLE;
                end
                else
                begin
                    retry_d = retry_q + 2'h1;
                    st_d = apth_pkg::ST_RETRY_WAIT;
                end
            end
            apth_pkg::ST_RETRY_WAIT:
            begin
                if (dlyDone)
                begin
                    unit_d = '0;
                    sum_d = '0;
                    mode_d = 1'b1;
                    st_d = apth_pkg::ST_REQ_HI;
                end
            end
        endcase
        // a stalled handshake or an overlong mode ends the transfer
        if (inXfer && (modeDone || hsDone))
        begin
            commErr_d = 1'b1;
            evComm = 1'b1;
            mode_d = 1'b0;
            req_d = 1'b0;
            st_d = apth_pkg::ST_IDLE;
        end
        // dropping servo-on abandons the transfer without a flag
        if (!rif.servoOn && st_q != apth_pkg::ST_IDLE)
        begin
            mode_d = 1'b0;
            req_d = 1'b0;
            st_d = apth_pkg::ST_IDLE;
        end
        if (homeStart)
        begin
            presPos_d = rif.homeAddr;
            load_d = 1'b1;
        end
    end

    assign evHome = clrOn_q && clrDone;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= apth_pkg::ST_IDLE;
            stPrev_q <= apth_pkg::ST_IDLE;
            abs_q <= '0;
            sum_q <= '0;
            csum_q <= '0;
            unit_q <= '0;
            retry_q <= '0;
            commErr_q <= 1'b0;
            csumErr_q <= 1'b0;
            valid_q <= 1'b0;
            mode_q <= 1'b0;
            req_q <= 1'b0;
            presPos_q <= '0;
            load_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            stPrev_q <= st_q;
            abs_q <= abs_d;
            sum_q <= sum_d;
            csum_q <= csum_d;
            unit_q <= unit_d;
            retry_q <= retry_d;
            commErr_q <= commErr_d;
            csumErr_q <= csumErr_d;
            valid_q <= valid_d;
            mode_q <= mode_d;
            req_q <= req_d;
            presPos_q <= presPos_d;
            load_q <= load_d;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            clrOn_q <= 1'b0;
            servoPrev_q <= 1'b0;
            runPrev_q <= 1'b0;
            estopPrev_q <= 1'b0;
            btnPrev_q <= 1'b0;
            almRst_q <= 1'b0;
        end
        else
        begin
            clrOn_q <= homeStart || (clrOn_q && !clrDone);
            servoPrev_q <= rif.servoOn;
            runPrev_q <= controllerRun;
            estopPrev_q <= estopActive;
            btnPrev_q <= homingStartButton;
            almRst_q <= rif.almRstPulse;
        end
    end

    assign servoEnableCmd = rif.servoOn;
    assign xferMode = mode_q;
    assign absRequest = req_q;
    assign alarmResetOut = almRst_q;
    assign deviationClear = clrOn_q;
    assign brakeOut = !mode_q && brakeReleaseSignal;
    assign torqueLimitCmd = rif.torqueLimitEn && !motionInhibit;
    assign motionInhibit = st_q != apth_pkg::ST_IDLE;
    assign modHomeAddr = rif.homeAddr;
    assign modPresentPos = presPos_q;
    assign modLoad = load_q;

    assign rif.absPos = abs_q;
    assign rif.status = {
        !mode_q && sharedIn2,
        !mode_q && sharedIn1,
        !mode_q && sharedIn0,
        clrOn_q,
        csumErr_q,
        commErr_q,
        valid_q,
        mode_q
    };
    assign rif.events = {evHome, evCsum, evComm, evDone};
endmodule

// file: dv/apth_amp_model.sv
// behavioural amplifier answering the absolute position handshake
`timescale 1ns/1ps
module apth_amp_model (
    // clock
    input wire logic clk,
    // controller pins
    input wire logic xferMode,
    input wire logic absRequest,
    // scenario controls
    input wire logic [31:0] pos,
    input wire logic badSum,
    input wire logic mute,
    input wire logic slow,
    input wire logic [2:0] stat,
    // shared outputs
    output logic sharedIn0,
    output logic sharedIn1,
    output logic sharedIn2
);
    logic rdy, go;
    logic [1:0] bits;
    logic [1:0] tick = 2'h0;
    int unit;

    function automatic logic [1:0] unitBits(input int u);
        logic [5:0] s;
        s = 6'h00;
        for (int k = 0; k < 16; k++)
            s = s + 6'(pos[2*k+:2]);
        if (badSum)
            s = s ^ 6'h01;
        return (u < 16) ? pos[2*u+:2] : s[2*(u-16)+:2];
    endfunction

    // slow mode answers only every fourth cycle
    assign go = !mute && (!slow || tick == 2'h0);

    always @(posedge clk)
    begin
        tick <= tick + 2'h1;
        if (!xferMode)
        begin
            unit <= 0;
            rdy <= 1'b1;
        end
        else if (go && absRequest && rdy)
            rdy <= 1'b0;
        else if (go && !absRequest && !rdy)
        begin
            bits <= unitBits(unit);
            unit <= unit + 1;
            rdy <= 1'b1;
        end
    end

    // data lines invert once released, so stale bits cannot pass
    assign {sharedIn1, sharedIn0} = !xferMode ? stat[1:0] :
        (rdy ? bits : ~bits);
    assign sharedIn2 = xferMode ? rdy : stat[2];
endmodule

// file: dv/apth_host_asserts.sv
// port assertions for the absolute position transfer host
`timescale 1ns/1ps
module apth_host_asserts #(
    parameter int MODE_TIMEOUT = 2000,
    parameter int HS_TIMEOUT = 200,
    parameter int CLEAR_PULSE = 30
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // watched ports
    input wire logic brakeReleaseSignal,
    input wire logic xferMode,
    input wire logic absRequest,
    input wire logic deviationClear,
    input wire logic brakeOut,
    input wire logic torqueLimitCmd,
    input wire logic controllerRun,
    input wire logic servoEnableCmd,
    input wire logic motionInhibit,
    input wire logic [31:0] modHomeAddr,
    input wire logic [31:0] modPresentPos,
    input wire logic modLoad
);
    int clrCnt_q, modeCnt_q, reqCnt_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            clrCnt_q <= 0;
            modeCnt_q <= 0;
            reqCnt_q <= 0;
        end
        else
        begin
            clrCnt_q <= deviationClear ? clrCnt_q + 1 : 0;
            modeCnt_q <= xferMode ? modeCnt_q + 1 : 0;
            reqCnt_q <= absRequest ? reqCnt_q + 1 : 0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_CLR_LEN: assert property (
        $fell(deviationClear) |-> clrCnt_q == CLEAR_PULSE)
        else $error("clear pulse length wrong");
    AST_CLR_HOME: assert property (
        $rose(deviationClear) |-> modLoad && !xferMode)
        else $error("clear raised outside homing");
    AST_HOME_POS: assert property (
        $rose(deviationClear) |-> modPresentPos == modHomeAddr)
        else $error("present position not home address");
    AST_INHIBIT: assert property (xferMode |-> motionInhibit)
        else $error("motion allowed during transfer");
    AST_NO_TLIM: assert property (xferMode |-> !torqueLimitCmd)
        else $error("torque limit on during transfer");
    AST_BRAKE: assert property (
        brakeOut == (brakeReleaseSignal && !xferMode))
        else $error("brake output not gated by mode");
    AST_RUN_TRIG: assert property (
        $rose(controllerRun) && servoEnableCmd && !motionInhibit &&
        !xferMode && !deviationClear |-> ##[1:3] xferMode)
        else $error("run edge did not start transfer");
    AST_REQ_AFTER: assert property ($rose(xferMode) |=> absRequest)
        else $error("request not raised after mode");
    AST_MODE_TO: assert property (modeCnt_q <= MODE_TIMEOUT + 2)
        else $error("transfer mode outlived timeout");
    AST_REQ_TO: assert property (reqCnt_q <= HS_TIMEOUT + 2)
        else $error("request outlived timeout");

    COV_DONE: cover property (modLoad && !deviationClear);
    COV_RETRY: cover property ($fell(xferMode) ##[1:40] $rose(xferMode));
    COV_HOME: cover property ($fell(deviationClear));
endmodule

bind apth_host apth_host_asserts #(.MODE_TIMEOUT(MODE_TIMEOUT),
    .HS_TIMEOUT(HS_TIMEOUT), .CLEAR_PULSE(CLEAR_PULSE)) u_asserts (
    .clk(clk), .nrst(nrst), .brakeReleaseSignal(brakeReleaseSignal),
    .xferMode(xferMode), .absRequest(absRequest),
    .deviationClear(deviationClear), .brakeOut(brakeOut),
    .torqueLimitCmd(torqueLimitCmd), .controllerRun(controllerRun),
    .servoEnableCmd(servoEnableCmd), .motionInhibit(motionInhibit),
    .modHomeAddr(modHomeAddr), .modPresentPos(modPresentPos),
    .modLoad(modLoad));

// file: dv/apth_host_tb.sv
// self-checking bench for the absolute position transfer host
`timescale 1ns/1ps
module apth_host_tb;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, pos, hm, mhA, mpP;
    logic s0, s1, s2, brk, servo, xferMode, absReq, almOut, devClr;
    logic brkOut, tlim, run, estop, homeBtn, inhib, modLoad;
    logic badSum, mute, slow, slvErr, xPrev;
    logic [2:0] stat;
    int fails, cmp_count, starts, seed;
    int unsigned expQ[$];

    apth_host #(.MODE_TIMEOUT(2000), .HS_TIMEOUT(200), .SAMPLE_DELAY(10),
        .RETRY_WAIT(20), .CLEAR_PULSE(30)) dut (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .sharedIn0(s0),
        .sharedIn1(s1), .sharedIn2(s2), .brakeReleaseSignal(brk),
        .servoEnableCmd(servo), .xferMode(xferMode), .absRequest(absReq),
        .alarmResetOut(almOut), .deviationClear(devClr), .brakeOut(brkOut),
        .torqueLimitCmd(tlim), .controllerRun(run), .estopActive(estop),
        .homingStartButton(homeBtn), .motionInhibit(inhib),
        .modHomeAddr(mhA), .modPresentPos(mpP), .modLoad(modLoad));
    apth_amp_model amp (.clk(clk), .xferMode(xferMode), .absRequest(absReq),
        .pos(pos), .badSum(badSum), .mute(mute), .slow(slow), .stat(stat),
        .sharedIn0(s0), .sharedIn1(s1), .sharedIn2(s2));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // random brake input keeps the brake gating busy all run
    always @(posedge clk)
    begin
        brk <= 1'($random(seed));
        xPrev <= xferMode;
        if (xferMode === 1'b1 && xPrev === 1'b0)
            starts++;
    end

    task automatic test_done;
        $display("TB: compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("ERROR %s exp %h got %h", n, e, g);
            fails++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        chk("pready", 1'b1, pready);
        if (n == 20)
            test_done();
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdc(input string n, input logic [7:0] a,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask

    task automatic waitIrq(input int lim);
        int n = 0;
        while (irq !== 1'b1 && n < lim)
        begin
            n++;
            @(posedge clk);
        end
        chk("irq", 1'b1, irq);
        if (n == lim)
            test_done();
    endtask

    initial
    begin
        seed = 32'h4350d7d2;
        {psel, penable, pwrite, run, estop, homeBtn} = 6'h00;
        {badSum, mute, slow, stat, paddr, pwdata, pos} = 78'h0;
        nrst = 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdc("ctrl", apth_pkg::CTRL_OFS, 32'h0);
        rdc("home", apth_pkg::HOME_OFS, 32'h0);
        rdc("mask", apth_pkg::IRQ_MASK_OFS, 32'h0);
        rdc("unmapped", 8'h1C, 32'h0);
        chk("slverr", 1'b1, slvErr);
        apb(1'b1, apth_pkg::IRQ_MASK_OFS, 32'h0000000F);
        // servo rise, start, run rise, alarm reset, e-stop release
        for (int k = 0; k < 5; k++)
        begin
            pos <= $random(seed);
            slow <= 1'(k);
            @(posedge clk);
            expQ.push_back(pos);
            if (k == 2 || k == 4)
            begin
                {run, estop} <= {1'b1, k == 4};
                @(posedge clk);
                estop <= 1'b0;
            end
            else
                apb(1'b1, k ? apth_pkg::CMD_OFS : apth_pkg::CTRL_OFS,
                    k == 3 ? 32'h2 : 32'h1);
            if (k == 3)
                chk("alarmOut", 2'h3, {servo, almOut});
            waitIrq(8000);
            rdc("pos", apth_pkg::POS_OFS, expQ.pop_front());
            rdc("done", apth_pkg::IRQ_STAT_OFS, 32'h1);
            apb(1'b1, apth_pkg::IRQ_STAT_OFS, 32'h0000000F);
            chk("irqclr", 1'b0, irq);
            $display("TB: trigger %0d done", k);
        end
        badSum <= 1'b1;
        starts = 0;
        apb(1'b1, apth_pkg::CMD_OFS, 32'h1);
        waitIrq(20000);
        chk("attempts", 4, starts);
        rdc("csum", apth_pkg::IRQ_STAT_OFS, 32'h4);
        apb(1'b1, apth_pkg::IRQ_STAT_OFS, 32'h0000000F);
        {badSum, mute} <= 2'b01;
        apb(1'b1, apth_pkg::CMD_OFS, 32'h1);
        waitIrq(3000);
        rdc("comm", apth_pkg::IRQ_STAT_OFS, 32'h2);
        chk("absreq", 1'b0, absReq);
        apb(1'b1, apth_pkg::IRQ_STAT_OFS, 32'h0000000F);
        {mute, stat} <= 4'h7;
        apb(1'b1, apth_pkg::CTRL_OFS, 32'h5);
        apb(1'b0, apth_pkg::STAT_OFS, 32'h0);
        chk("status", 3'h7, rd[7:5]);
        chk("tlimIdle", 1'b1, tlim);
        apb(1'b1, apth_pkg::CMD_OFS, 32'h1);
        apb(1'b0, apth_pkg::STAT_OFS, 32'h0);
        chk("statusXfer", 4'h1, {rd[7:5], rd[0]});
        chk("tlimXfer", 1'b0, tlim);
        waitIrq(8000);
        apb(1'b0, apth_pkg::STAT_OFS, 32'h0);
        chk("noErr", 2'h0, rd[3:2]);
        apb(1'b1, apth_pkg::IRQ_STAT_OFS, 32'h0000000F);
        $display("TB: error paths done");
        for (int k = 0; k < 2; k++)
        begin
            hm = $random(seed);
            apb(1'b1, apth_pkg::HOME_OFS, hm);
            apb(1'b1, apth_pkg::CTRL_OFS, 32'h3);
            if (k == 0)
            begin
                homeBtn <= 1'b1;
                @(posedge clk);
                homeBtn <= 1'b0;
            end
            else
                apb(1'b1, apth_pkg::CMD_OFS, 32'h4);
            waitIrq(500);
            chk("presentPos", hm, mpP);
            chk("homeAddr", hm, mhA);
            rdc("homeEnd", apth_pkg::IRQ_STAT_OFS, 32'h8);
            apb(1'b1, apth_pkg::IRQ_STAT_OFS, 32'h0000000F);
            $display("TB: homing %0d done", k);
        end
        test_done();
    end
endmodule
